//--- isam_defs.svh
`ifndef ISAM_DEFS_SVH
`define ISAM_DEFS_SVH

// ============================================================
// Register word addresses on the plain register port.
`define ISAM_ADDR_W           4
`define ISAM_DATA_W           16
`define ISAM_OFS_STATUS       4'h0
`define ISAM_OFS_MASK         4'h1
`define ISAM_OFS_CTRL         4'h2
`define ISAM_OFS_OWN_ADDR     4'h3
`define ISAM_OFS_TX_HOLD      4'h4
`define ISAM_OFS_RX_HOLD      4'h5
`define ISAM_OFS_INT_STATUS   4'h6
`define ISAM_OFS_INT_ENABLE   4'h7
`define ISAM_OFS_INT_CLEAR    4'h8

// ============================================================
// Field positions of the serial bus status register.
`define ISAM_ST_ACK_SEEN      15
`define ISAM_ST_MASTER_TX     14
`define ISAM_ST_COLLISION     10
`define ISAM_ST_GEN_CALL      9
`define ISAM_ST_TEN_MATCH     8
`define ISAM_ST_WR_COLLISION  7
`define ISAM_ST_RX_OVERFLOW   6
`define ISAM_ST_DATA_NOT_ADDR 5
`define ISAM_ST_STOP_SEEN     4
`define ISAM_ST_START_SEEN    3
`define ISAM_ST_READ_NOT_WR   2
`define ISAM_ST_RX_FULL       1
`define ISAM_ST_TX_FULL       0

// Field positions of the control register.
`define ISAM_CT_ACCEPT_ALL    11
`define ISAM_CT_TEN_BIT       10
`define ISAM_CT_GEN_CALL_EN   7

// ============================================================
// Address constants, widths and reset values.
`define ISAM_MASK_W           10
`define ISAM_TEN_PREFIX       5'h1e
`define ISAM_GEN_CALL_ADDR    8'h00
`define ISAM_RSV_LOW          4'h0
`define ISAM_RSV_HIGH         4'hf
`define ISAM_MASK_RESET       10'h000
`define ISAM_READ_ZERO        16'h0000

// Interrupt event bit positions.
`define ISAM_EVT_W            8
`define ISAM_EV_ADDR_MATCH    0
`define ISAM_EV_RX_BYTE       1
`define ISAM_EV_COLLISION     2
`define ISAM_EV_WR_COLLISION  3
`define ISAM_EV_OVERFLOW      4
`define ISAM_EV_START         5
`define ISAM_EV_STOP          6
`define ISAM_EV_ACK_SLOT      7

`endif

//--- isam_pkg.sv
`include "isam_defs.svh"

package isam_pkg;

  typedef logic [`ISAM_ADDR_W-1:0] isam_addr_t;
  typedef logic [`ISAM_DATA_W-1:0] isam_data_t;
  typedef logic [`ISAM_EVT_W-1:0]  isam_evt_t;
  typedef logic [`ISAM_MASK_W-1:0] isam_mask_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_ADDR   = 2'b01,
    PH_TEN_LO = 2'b10,
    PH_DATA   = 2'b11
  } isam_phase_e;

  typedef struct packed {
    isam_evt_t stat;
    isam_evt_t en;
    logic      irq;
  } isam_irq_s;

  typedef struct packed {
    isam_phase_e phase;
    logic        ackSeenFlag;
    logic        masterTxActive;
    logic        collisionFlag;
    logic        generalCallSeen;
    logic        tenBitMatch;
    logic        writeCollisionFlag;
    logic        rxOverflowFlag;
    logic        dataNotAddr;
    logic        stopSeen;
    logic        startSeen;
    logic        readNotWrite;
    logic        rxFullFlag;
    logic        txFullFlag;
    logic        tenHighOk;
    isam_mask_t  addrDontCare;
    logic        acceptAllModeEn;
    logic        tenBitMode;
    logic        generalCallEnable;
    isam_mask_t  ownAddr;
    logic [7:0]  txHoldingReg;
    logic [7:0]  rxHoldingReg;
    isam_data_t  rdData;
    logic        addrAck;
  } isam_core_s;

endpackage

//--- isam_addr_match.sv
`timescale 1ns/100ps
`include "isam_defs.svh"

module isam_addr_match
  import isam_pkg::*;
(
  input  wire logic [7:0]        rxByte,
  input  wire isam_pkg::isam_mask_t ownAddr,
  input  wire isam_pkg::isam_mask_t addrDontCare,
  input  wire logic              tenBitMode,
  input  wire logic              acceptAllModeEn,
  input  wire logic              generalCallEnable,
  input  wire logic              secondByte,
  output logic                   devMatch,
  output logic                   tenHighMatch,
  output logic                   genCallMatch
);

  logic reserved;
  logic [6:0] diff7;
  logic [7:0] diffLo;
  logic [1:0] diffHi;

  // ==========================================================
  // Masked comparison; a one in the mask makes that bit free.
  always_comb begin
    diff7  = (rxByte[7:1] ^ ownAddr[6:0]) & ~addrDontCare[6:0];
    diffLo = (rxByte ^ ownAddr[7:0]) & ~addrDontCare[7:0];
    diffHi = (rxByte[2:1] ^ ownAddr[9:8]) & ~addrDontCare[9:8];
    reserved = (rxByte[7:4] == `ISAM_RSV_LOW) || (rxByte[7:4] == `ISAM_RSV_HIGH);
    genCallMatch = generalCallEnable && (rxByte == `ISAM_GEN_CALL_ADDR);
    tenHighMatch = tenBitMode && !secondByte && (rxByte[7:3] == `ISAM_TEN_PREFIX)
                   && (acceptAllModeEn || (diffHi == 2'h0));
    if (secondByte) begin
      devMatch = acceptAllModeEn || (diffLo == 8'h00);
    end else if (tenBitMode) begin
      devMatch = 1'b0;
    end else begin
      devMatch = acceptAllModeEn || (!reserved && (diff7 == 7'h00));
    end
  end

endmodule

//--- isam_irq.sv
`timescale 1ns/100ps
`include "isam_defs.svh"

module isam_irq
  import isam_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire isam_pkg::isam_evt_t evt,
  input  wire logic             enWr,
  input  wire logic             clrWr,
  input  wire isam_pkg::isam_evt_t wrData,
  output isam_pkg::isam_evt_t   stat,
  output isam_pkg::isam_evt_t   en,
  output logic                  irq
);

  isam_irq_s st_r;
  isam_irq_s st_nxt;

  // ==========================================================
  // Sticky events; a new event wins over a clear in the same cycle.
  always_comb begin
    st_nxt = st_r;
    if (clrWr) begin
      st_nxt.stat = st_r.stat & ~wrData;
    end
    st_nxt.stat = st_nxt.stat | evt;
    if (enWr) begin
      st_nxt.en = wrData;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.en);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat = st_r.stat;
  assign en   = st_r.en;
  assign irq  = st_r.irq;

endmodule

//--- isam_status_mask.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "isam_defs.svh"

module isam_status_mask
  import isam_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire isam_pkg::isam_addr_t regAddr,
  input  wire isam_pkg::isam_data_t regWrData,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output isam_pkg::isam_data_t  regRdData,
  input  wire logic             masterMode,
  input  wire logic             busBusy,
  input  wire logic             startDet,
  input  wire logic             restartDet,
  input  wire logic             stopDet,
  input  wire logic             rxByteValid,
  input  wire logic [7:0]       rxShiftReg,
  input  wire logic             ackSlotEnd,
  input  wire logic             ackNack,
  input  wire logic             masterTxBegin,
  input  wire logic             collisionDet,
  input  wire logic             txDone,
  input  wire logic             slaveTxDone,
  output logic [7:0]            txData,
  output logic                  txPending,
  output logic                  addrAck,
  output logic                  irq
);

  isam_core_s core_r;
  isam_core_s core_nxt;

  logic       devMatch;
  logic       tenHighMatch;
  logic       genCallMatch;
  logic       wrStatus;
  logic       wrMask;
  logic       wrCtrl;
  logic       wrOwn;
  logic       wrTx;
  logic       wrIntEn;
  logic       wrIntClr;
  logic       rdRx;
  logic       slaveRx;
  logic       loadRx;
  isam_evt_t  evt;
  isam_evt_t  intStat;
  isam_evt_t  intEn;
  isam_data_t statusWord;
  isam_data_t ctrlWord;

  // ==========================================================
  // Address comparison against the masked own address.
  isam_addr_match u_match (
    .rxByte            (rxShiftReg),
    .ownAddr           (core_r.ownAddr),
    .addrDontCare      (core_r.addrDontCare),
    .tenBitMode        (core_r.tenBitMode),
    .acceptAllModeEn   (core_r.acceptAllModeEn),
    .generalCallEnable (core_r.generalCallEnable),
    .secondByte        (core_r.phase == PH_TEN_LO),
    .devMatch          (devMatch),
    .tenHighMatch      (tenHighMatch),
    .genCallMatch      (genCallMatch)
  );

  // ==========================================================
  // Register port decode.
  always_comb begin
    wrStatus = 1'b0;
    wrMask   = 1'b0;
    wrCtrl   = 1'b0;
    wrOwn    = 1'b0;
    wrTx     = 1'b0;
    wrIntEn  = 1'b0;
    wrIntClr = 1'b0;
    if (regAddr == `ISAM_OFS_STATUS) begin
      wrStatus = regWr;
    end else if (regAddr == `ISAM_OFS_MASK) begin
      wrMask = regWr;
    end else if (regAddr == `ISAM_OFS_CTRL) begin
      wrCtrl = regWr;
    end else if (regAddr == `ISAM_OFS_OWN_ADDR) begin
      wrOwn = regWr;
    end else if (regAddr == `ISAM_OFS_TX_HOLD) begin
      wrTx = regWr;
    end else if (regAddr == `ISAM_OFS_INT_ENABLE) begin
      wrIntEn = regWr;
    end else if (regAddr == `ISAM_OFS_INT_CLEAR) begin
      wrIntClr = regWr;
    end
    rdRx = regRd && (regAddr == `ISAM_OFS_RX_HOLD);
  end

  // ==========================================================
  // Read views of the status and control registers.
  always_comb begin
    statusWord = `ISAM_READ_ZERO;
    statusWord[`ISAM_ST_ACK_SEEN]      = core_r.ackSeenFlag;
    statusWord[`ISAM_ST_MASTER_TX]     = core_r.masterTxActive;
    statusWord[`ISAM_ST_COLLISION]     = core_r.collisionFlag;
    statusWord[`ISAM_ST_GEN_CALL]      = core_r.generalCallSeen;
    statusWord[`ISAM_ST_TEN_MATCH]     = core_r.tenBitMatch;
    statusWord[`ISAM_ST_WR_COLLISION]  = core_r.writeCollisionFlag;
    statusWord[`ISAM_ST_RX_OVERFLOW]   = core_r.rxOverflowFlag;
    statusWord[`ISAM_ST_DATA_NOT_ADDR] = core_r.dataNotAddr;
    statusWord[`ISAM_ST_STOP_SEEN]     = core_r.stopSeen;
    statusWord[`ISAM_ST_START_SEEN]    = core_r.startSeen;
    statusWord[`ISAM_ST_READ_NOT_WR]   = core_r.readNotWrite;
    statusWord[`ISAM_ST_RX_FULL]       = core_r.rxFullFlag;
    statusWord[`ISAM_ST_TX_FULL]       = core_r.txFullFlag;
    ctrlWord = `ISAM_READ_ZERO;
    ctrlWord[`ISAM_CT_ACCEPT_ALL]  = core_r.acceptAllModeEn;
    ctrlWord[`ISAM_CT_TEN_BIT]     = core_r.tenBitMode;
    ctrlWord[`ISAM_CT_GEN_CALL_EN] = core_r.generalCallEnable;
  end

  // ==========================================================
  // Next state of all flags but the interrupt status flags (kept in isam_irq), holding registers and the address phase.
  always_comb begin
    core_nxt = core_r;
    core_nxt.addrAck = 1'b0;
    slaveRx = 1'b0;
    loadRx  = 1'b0;
    evt     = '0;

    // Software side of the register port.
    if (wrStatus) begin
      if (!regWrData[`ISAM_ST_COLLISION]) begin
        core_nxt.collisionFlag = 1'b0;
      end
      if (!regWrData[`ISAM_ST_WR_COLLISION]) begin
        core_nxt.writeCollisionFlag = 1'b0;
      end
      if (!regWrData[`ISAM_ST_RX_OVERFLOW]) begin
        core_nxt.rxOverflowFlag = 1'b0;
      end
    end
    if (wrMask) begin
      core_nxt.addrDontCare = regWrData[`ISAM_MASK_W-1:0];
    end
    if (wrCtrl) begin
      core_nxt.acceptAllModeEn   = regWrData[`ISAM_CT_ACCEPT_ALL];
      core_nxt.tenBitMode        = regWrData[`ISAM_CT_TEN_BIT];
      core_nxt.generalCallEnable = regWrData[`ISAM_CT_GEN_CALL_EN];
    end
    if (wrOwn) begin
      core_nxt.ownAddr = regWrData[`ISAM_MASK_W-1:0];
    end
    if (rdRx) begin
      core_nxt.rxFullFlag = 1'b0;
    end

    // Transmit completion clears first, so a same-cycle write still sets.
    if (txDone) begin
      core_nxt.txFullFlag = 1'b0;
    end
    if (wrTx) begin
      if (busBusy) begin
        core_nxt.writeCollisionFlag = 1'b1;
        evt[`ISAM_EV_WR_COLLISION] = 1'b1;
      end else begin
        core_nxt.txHoldingReg = regWrData[7:0];
        core_nxt.txFullFlag   = 1'b1;
      end
    end

    // Acknowledge slot and master transmit progress.
    if (masterTxBegin) begin
      core_nxt.masterTxActive = 1'b1;
    end
    if (ackSlotEnd) begin
      core_nxt.ackSeenFlag = ackNack;
      evt[`ISAM_EV_ACK_SLOT] = 1'b1;
      if (masterMode && !masterTxBegin) begin
        core_nxt.masterTxActive = 1'b0;
      end
    end
    if (collisionDet && masterMode) begin
      core_nxt.collisionFlag = 1'b1;
      evt[`ISAM_EV_COLLISION] = 1'b1;
    end

    // Bus conditions; a stop ends any slave transaction.
    if (startDet || restartDet) begin
      core_nxt.startSeen = 1'b1;
      core_nxt.stopSeen  = 1'b0;
      core_nxt.phase     = PH_ADDR;
      evt[`ISAM_EV_START] = 1'b1;
      if (startDet) begin
        core_nxt.tenHighOk = 1'b0;
      end
    end else if (stopDet) begin
      core_nxt.startSeen       = 1'b0;
      core_nxt.stopSeen        = 1'b1;
      core_nxt.generalCallSeen = 1'b0;
      core_nxt.tenBitMatch     = 1'b0;
      core_nxt.tenHighOk       = 1'b0;
      core_nxt.phase           = PH_IDLE;
      evt[`ISAM_EV_STOP] = 1'b1;
    end else if (rxByteValid && !masterMode) begin
      case (core_r.phase)
        PH_ADDR: begin
          if (genCallMatch) begin
            core_nxt.generalCallSeen = 1'b1;
            core_nxt.dataNotAddr     = 1'b0;
            core_nxt.readNotWrite    = 1'b0;
            core_nxt.phase           = PH_DATA;
            slaveRx = 1'b1;
          end else if (devMatch) begin
            core_nxt.dataNotAddr  = 1'b0;
            core_nxt.readNotWrite = rxShiftReg[0];
            core_nxt.phase        = PH_DATA;
            slaveRx = 1'b1;
          end else if (tenHighMatch && !rxShiftReg[0]) begin
            core_nxt.tenHighOk = 1'b1;
            core_nxt.phase     = PH_TEN_LO;
            slaveRx = 1'b1;
          end else if (tenHighMatch && core_r.tenHighOk) begin
            core_nxt.dataNotAddr  = 1'b0;
            core_nxt.readNotWrite = 1'b1;
            core_nxt.phase        = PH_DATA;
            slaveRx = 1'b1;
          end else begin
            core_nxt.phase = PH_IDLE;
          end
          core_nxt.addrAck = slaveRx;
          evt[`ISAM_EV_ADDR_MATCH] = slaveRx;
        end
        PH_TEN_LO: begin
          if (devMatch) begin
            core_nxt.tenBitMatch  = 1'b1;
            core_nxt.dataNotAddr  = 1'b0;
            core_nxt.readNotWrite = 1'b0;
            core_nxt.phase        = PH_DATA;
            core_nxt.addrAck      = 1'b1;
            evt[`ISAM_EV_ADDR_MATCH] = 1'b1;
            slaveRx = 1'b1;
          end else begin
            core_nxt.phase     = PH_IDLE;
            core_nxt.tenHighOk = 1'b0;
          end
        end
        PH_DATA: begin
          core_nxt.dataNotAddr = 1'b1;
          slaveRx = 1'b1;
        end
        default: begin
          core_nxt.phase = PH_IDLE;
        end
      endcase
    end

    // A finished slave transmission marks the last byte as data.
    if (slaveTxDone && core_r.phase == PH_DATA) begin
      core_nxt.dataNotAddr = 1'b1;
    end

    // Move the shifted byte to the holding register unless it is unread.
    loadRx = (slaveRx || (rxByteValid && masterMode));
    if (loadRx) begin
      if (core_r.rxFullFlag && !rdRx) begin
        core_nxt.rxOverflowFlag = 1'b1;
        evt[`ISAM_EV_OVERFLOW] = 1'b1;
      end else begin
        core_nxt.rxHoldingReg = rxShiftReg;
        core_nxt.rxFullFlag   = 1'b1;
        evt[`ISAM_EV_RX_BYTE] = 1'b1;
      end
    end

    // Read data stand in the cycle after the strobe; unmapped reads zero.
    core_nxt.rdData = `ISAM_READ_ZERO;
    if (regRd) begin
      if (regAddr == `ISAM_OFS_STATUS) begin
        core_nxt.rdData = statusWord;
      end else if (regAddr == `ISAM_OFS_MASK) begin
        core_nxt.rdData = {6'h00, core_r.addrDontCare};
      end else if (regAddr == `ISAM_OFS_CTRL) begin
        core_nxt.rdData = ctrlWord;
      end else if (regAddr == `ISAM_OFS_OWN_ADDR) begin
        core_nxt.rdData = {6'h00, core_r.ownAddr};
      end else if (regAddr == `ISAM_OFS_TX_HOLD) begin
        core_nxt.rdData = {8'h00, core_r.txHoldingReg};
      end else if (regAddr == `ISAM_OFS_RX_HOLD) begin
        core_nxt.rdData = {8'h00, core_r.rxHoldingReg};
      end else if (regAddr == `ISAM_OFS_INT_STATUS) begin
        core_nxt.rdData = {8'h00, intStat};
      end else if (regAddr == `ISAM_OFS_INT_ENABLE) begin
        core_nxt.rdData = {8'h00, intEn};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  // ==========================================================
  // Interrupt status, enable and clear.
  isam_irq u_irq (
    .ref_clk (ref_clk),
    .rst     (rst),
    .evt     (evt),
    .enWr    (wrIntEn),
    .clrWr   (wrIntClr),
    .wrData  (regWrData[`ISAM_EVT_W-1:0]),
    .stat    (intStat),
    .en      (intEn),
    .irq     (irq)
  );

  assign regRdData = core_r.rdData;
  assign txData    = core_r.txHoldingReg;
  assign txPending = core_r.txFullFlag;
  assign addrAck   = core_r.addrAck;

endmodule

//--- isam_status_mask_properties.sv
`timescale 1ns/100ps
module isam_status_mask_properties
  import isam_pkg::*;
(
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire isam_pkg::isam_addr_t regAddr,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire isam_pkg::isam_data_t regRdData,
  input wire logic                 busBusy,
  input wire logic                 rxByteValid,
  input wire logic                 txDone,
  input wire logic                 txPending,
  input wire logic                 addrAck
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rd_idle; !regRd |=> regRdData == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_mask_top; regRd && regAddr == 4'h1 |=> regRdData[15:10] == 6'h00; endproperty
  a_mask_top: assert property (p_mask_top) else $error("mask top bits set");
  property p_tx_set; regWr && regAddr == 4'h4 && !busBusy |=> txPending; endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx full not set");
  property p_tx_refuse; regWr && regAddr == 4'h4 && busBusy && !txPending |=> !txPending; endproperty
  a_tx_refuse: assert property (p_tx_refuse) else $error("busy write taken");
  property p_tx_clr; txDone && !(regWr && regAddr == 4'h4) |=> !txPending; endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx full not cleared");
  property p_tx_keep; txPending && !txDone |=> txPending; endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("tx full lost");
  property p_ack_cause; addrAck |-> $past(rxByteValid); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without byte");
  property p_ack_pulse; addrAck |=> !addrAck; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
endmodule

//--- isam_bus_peer.sv
`timescale 1ns/100ps
module isam_bus_peer (
  input  wire logic  ref_clk,
  output logic       startDet,
  output logic       stopDet,
  output logic       rxByteValid,
  output logic [7:0] rxShiftReg,
  output logic       ackSlotEnd,
  output logic       ackNack
);
  initial begin
    {startDet, stopDet, rxByteValid, ackSlotEnd, ackNack} = 5'h00;
    rxShiftReg = 8'h00;
  end
  task automatic start_cond();
    @(posedge ref_clk) startDet <= 1'b1;
    @(posedge ref_clk) startDet <= 1'b0;
  endtask
  task automatic stop_cond();
    @(posedge ref_clk) stopDet <= 1'b1;
    @(posedge ref_clk) stopDet <= 1'b0;
  endtask
  task automatic ack_slot(input logic nack);
    @(posedge ref_clk) begin ackSlotEnd <= 1'b1; ackNack <= nack; end
    @(posedge ref_clk) begin ackSlotEnd <= 1'b0; ackNack <= ~nack; end
  endtask
  // The byte is held one cycle, then the shift lines show its inverse.
  task automatic send_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk) begin rxShiftReg <= b; rxByteValid <= 1'b1; end
    @(posedge ref_clk) begin rxShiftReg <= ~b; rxByteValid <= 1'b0; end
    ack_slot(1'b0);
  endtask
endmodule

//--- test_isam_status_mask.sv
`timescale 1ns/100ps
module test_isam_status_mask;
  import isam_pkg::*;
  logic       ref_clk, rst, regWr, regRd, masterMode, busBusy, startDet, stopDet;
  logic       rxByteValid, ackSlotEnd, ackNack, txPending, addrAck, irq;
  logic [4:0] ev;
  logic [7:0] rxShiftReg, txData;
  isam_addr_t regAddr;
  isam_data_t regWrData, regRdData, rd;
  int         n_mismatch, cmp_count, nAck;
  isam_status_mask uut (.ref_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .masterMode, .busBusy, .startDet, .restartDet(ev[3]), .stopDet, .rxByteValid, .rxShiftReg,
    .ackSlotEnd, .ackNack, .masterTxBegin(ev[0]), .collisionDet(ev[1]), .txDone(ev[2]),
    .slaveTxDone(ev[4]), .txData, .txPending, .addrAck, .irq);
  isam_bus_peer peer (.ref_clk, .startDet, .stopDet, .rxByteValid, .rxShiftReg, .ackSlotEnd,
    .ackNack);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (addrAck === 1'b1) nAck++;
  // ==========================================================
  // Bus cycles and comparison.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input isam_addr_t a, input isam_data_t d);
    @(posedge ref_clk) begin regWr <= 1'b1; regAddr <= a; regWrData <= d; end
    @(posedge ref_clk) regWr <= 1'b0;
    #1;
  endtask
  task automatic rdreg(input isam_addr_t a);
    @(posedge ref_clk) begin regRd <= 1'b1; regAddr <= a; end
    @(posedge ref_clk) regRd <= 1'b0;
    #1 rd = regRdData;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge ref_clk) ev <= m;
    @(posedge ref_clk) ev <= 5'h00;
    #1;
  endtask
  task automatic try_addr(input logic [7:0] b, input logic exp);
    int n0;
    rdreg(4'h5);
    n0 = nAck;
    peer.start_cond();
    peer.send_byte(b, 0);
    peer.stop_cond();
    chk("match", 16'(nAck - n0), 16'(exp));
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_regs();
    rdreg(4'h0);
    chk("status reset", rd, 16'h0000);
    wr(4'h1, 16'hffff);
    rdreg(4'h1);
    chk("mask bits", rd, 16'h03ff);
    rdreg(4'hf);
    chk("unmapped", rd, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_slave();
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0052);
    wr(4'h7, 16'h00ff);
    peer.start_cond();
    rdreg(4'h0);
    chk("start", rd & 16'h0018, 16'h0008);
    peer.send_byte(8'ha5, 0);
    rdreg(4'h0);
    chk("addr flags", rd & 16'h8026, 16'h0006);
    chk("irq up", 16'(irq), 16'h0001);
    rdreg(4'h5);
    chk("rx byte", rd, 16'h00a5);
    rdreg(4'h0);
    chk("rx read", rd & 16'h0002, 16'h0000);
    peer.send_byte(8'h3c, 3);
    peer.send_byte(8'h3d, 0);
    rdreg(4'h0);
    chk("data ovf", rd & 16'h0062, 16'h0062);
    wr(4'h0, 16'h0000);
    rdreg(4'h0);
    chk("ovf clr", rd & 16'h0062, 16'h0022);
    peer.stop_cond();
    rdreg(4'h0);
    chk("stop", rd & 16'h0018, 16'h0010);
    wr(4'h7, 16'h0000);
    rdreg(4'h6);
    chk("irq masked", 16'(irq), 16'h0000);
    wr(4'h7, 16'h00ff);
    rdreg(4'h6);
    chk("int stat", rd, 16'h00f3);
    chk("irq again", 16'(irq), 16'h0001);
    wr(4'h8, 16'h00ff);
    rdreg(4'h6);
    chk("int clr", rd, 16'h0000);
    chk("irq cleared", 16'(irq), 16'h0000);
    $display("t_slave done");
  endtask
  task automatic t_mask();
    try_addr(8'ha6, 1'b0);
    wr(4'h1, 16'h0001);
    try_addr(8'ha6, 1'b1);
    wr(4'h1, 16'h03ff);
    try_addr(8'hf0, 1'b0);
    try_addr(8'h00, 1'b0);
    wr(4'h2, 16'h0080);
    try_addr(8'h00, 1'b1);
    wr(4'h2, 16'h0800);
    wr(4'h1, 16'h0000);
    try_addr(8'hf0, 1'b1);
    $display("t_mask done");
  endtask
  task automatic t_ten();
    int n0;
    rdreg(4'h5);
    wr(4'h3, 16'h02b7);
    wr(4'h2, 16'h0400);
    n0 = nAck;
    peer.start_cond();
    peer.send_byte(8'hf4, 0);
    peer.send_byte(8'hb7, 0);
    rdreg(4'h0);
    chk("ten write", rd & 16'h0124, 16'h0100);
    pulse(5'b01000);
    peer.send_byte(8'hf5, 0);
    chk("ten acks", 16'(nAck - n0), 16'h0003);
    rdreg(4'h0);
    chk("ten read", rd & 16'h0124, 16'h0104);
    pulse(5'b10000);
    rdreg(4'h0);
    chk("tx finished", rd & 16'h0020, 16'h0020);
    peer.stop_cond();
    rdreg(4'h0);
    chk("ten stop", rd & 16'h0100, 16'h0000);
    $display("t_ten done");
  endtask
  task automatic t_master();
    @(posedge ref_clk) masterMode <= 1'b1;
    wr(4'h4, 16'h005a);
    chk("tx full", 16'(txPending), 16'h0001);
    chk("tx data", 16'(txData), 16'h005a);
    pulse(5'b00001);
    rdreg(4'h0);
    chk("tx active", rd & 16'h4000, 16'h4000);
    peer.ack_slot(1'b1);
    rdreg(4'h0);
    chk("nack", rd & 16'hc000, 16'h8000);
    pulse(5'b00100);
    chk("tx empty", 16'(txPending), 16'h0000);
    @(posedge ref_clk) busBusy <= 1'b1;
    wr(4'h4, 16'h0011);
    chk("tx refused", 16'(txData), 16'h005a);
    pulse(5'b00010);
    rdreg(4'h0);
    chk("collisions", rd & 16'h0481, 16'h0480);
    wr(4'h0, 16'hffff);
    rdreg(4'h0);
    chk("keep on one", rd & 16'h0480, 16'h0480);
    wr(4'h0, 16'h0000);
    rdreg(4'h0);
    chk("clear on zero", rd & 16'h0480, 16'h0000);
    $display("t_master done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {rst, regWr, regRd, masterMode, busBusy} = 5'b10000;
    {ev, regAddr, regWrData} = 25'h0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_slave();
    t_mask();
    t_ten();
    t_master();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind isam_status_mask isam_status_mask_properties u_props (.ref_clk, .rst, .regAddr, .regWr,
  .regRd, .regRdData, .busBusy, .rxByteValid, .txDone, .txPending, .addrAck);
